/* File: pcfg_consts.svh */
// Constants for the power-up strap configuration capture block
`ifndef PCFG_CONSTS_SVH
`define PCFG_CONSTS_SVH
// Strap bus width and field positions
`define PCFG_STRAP_W        24
`define PCFG_POWERUP_STATUS_BITS_HI        23
`define PCFG_POWERUP_STATUS_BITS_LO        20
`define PCFG_CLASS_BIT      19
`define PCFG_PCI_ARB_BIT    18
`define PCFG_CPU_ARB_BIT    17
`define PCFG_BASE_HI        16
`define PCFG_BASE_LO        15
`define PCFG_RATIO_HI       14
`define PCFG_RATIO_LO       12
`define PCFG_P0W_HI         11
`define PCFG_P0W_LO         10
`define PCFG_P0_BOOT_BIT    9
`define PCFG_P1W_HI         8
`define PCFG_P1W_LO         7
`define PCFG_P1_BOOT_BIT    6
`define PCFG_P2W_HI         5
`define PCFG_P2W_LO         4
`define PCFG_P2_BOOT_BIT    3
`define PCFG_P3W_HI         2
`define PCFG_P3W_LO         1
`define PCFG_P3_BOOT_BIT    0
// Register group base address for strap code 00
`define PCFG_BASE_CODE0     2'h0
`define PCFG_BASE_ADDR0     32'hfeff0000
// Top boot address range
`define PCFG_BOOT_LO        32'hfff00000
`define PCFG_BOOT_HI        32'hffffffff
// Width codes
`define PCFG_P0_W16_CODE    2'h1
`define PCFG_P1_W16MUX_CODE 2'h3
// Settle countdown start value; capture lands on the fifth edge after reset release
`define PCFG_SETTLE_CYC     4'h3
// Register bus offsets
`define PCFG_REG_STATUS     8'h00
`define PCFG_REG_CONFIG     8'h04
`define PCFG_REG_BOOT       8'h08
`define PCFG_REG_BASE       8'h0c
`define PCFG_REG_RAW        8'h10
`endif

/* File: pcfg_pkg.sv */
// Types for the power-up strap configuration capture block
package pcfg_pkg;
  // Clock ratio selection decoded from the straps
  typedef enum logic [2:0] {
    PCFG_RATIO_RSV0 = 3'h0,
    PCFG_RATIO_3_2  = 3'h1,
    PCFG_RATIO_2_1  = 3'h2,
    PCFG_RATIO_5_2  = 3'h3,
    PCFG_RATIO_1_1  = 3'h4,
    PCFG_RATIO_RSV5 = 3'h5,
    PCFG_RATIO_3_1  = 3'h6,
    PCFG_RATIO_RSV7 = 3'h7
  } pcfg_ratio_t;

  // Capture sequence, Gray coded
  typedef enum logic [1:0] {
    PCFG_ST_SYNC   = 2'h0,
    PCFG_ST_SETTLE = 2'h1,
    PCFG_ST_LOCKED = 2'h3
  } pcfg_state_t;

  // Settings derived from the straps
  typedef struct packed {
    logic [3:0]  powerup_status_bits;
    logic        class_code_field;
    logic        pci_arb_en;
    logic        cpu_arb_en;
    logic [31:0] base_addr;
    logic        base_valid;
    pcfg_ratio_t ratio;
    logic        ratio_valid;
    logic [1:0]  port0_width_field;
    logic        port0_w16;
    logic [1:0]  port1_width_field;
    logic        port1_w16_mux;
    logic [1:0]  port2_width_field;
    logic [1:0]  port3_width_field;
    logic [3:0]  boot_en;
    logic [1:0]  boot_sel;
    logic        boot_valid;
  } pcfg_cfg_t;

  // All state of the capture block
  typedef struct packed {
    logic [23:0] sync1;
    logic [23:0] sync2;
    logic [23:0] raw;
    pcfg_state_t state;
    logic [3:0]  cnt;
    logic        locked;
    pcfg_cfg_t   cfg;
    logic [31:0] rdata;
  } pcfg_regs_t;
endpackage : pcfg_pkg

/* File: pcfg_strap_loader.sv */
// Power-up strap capture with decoded configuration outputs and register port
//
// How it works
// - Each strap bus pin level is one configuration bit, sampled at power-up reset.
// - Straps 23..20 become software readable power-up status bits 3..0.
// - Strap 19 picks class code: 0 bridge device, 1 message controller.
// - Strap 18 at 0 keeps the internal PCI arbiter disabled.
// - Strap 17 at 1 enables the internal processor-bus arbiter.
// - Straps 16..15 at 00 put the register group at feff0000.
// - Straps 14..12 select clock ratio; 000, 101 and 111 are reserved.
// - Straps 11..10 at 01 give port 0 a 16-bit data width.
// - Strap 9 enables or disables port 0 as reset-vector source.
// - Straps 8..7 at 11 give port 1 16-bit multiplexed legacy mode.
// - Port 1 is boot source only if strap 6 set and port 0 disabled.
// - Strap 3 at 0 excludes port 2 as reset-vector source.
// - Top boot range maps to port 0 first, else port 1.
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "pcfg_consts.svh"

module pcfg_strap_loader
  import pcfg_pkg::*;
#(
  parameter int STRAP_W = `PCFG_STRAP_W
) (
  // Clock and power-up reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_resetn,
  // Strap pins on the multiplexed port bus
  input  wire logic [STRAP_W-1:0] i_config_strap_bus,
  // Register port
  input  wire logic [7:0]        i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [31:0]            o_rdata,
  // Decoded configuration
  output logic                   o_cfg_valid,
  output logic [3:0]             o_powerup_status_bits,
  output logic                   o_class_code_field,
  output logic                   o_pci_arb_en,
  output logic                   o_cpu_arb_en,
  output logic [31:0]            o_bridge_register_group_base,
  output logic                   o_base_valid,
  output pcfg_ratio_t            o_clk_ratio,
  output logic                   o_clk_ratio_valid,
  output logic [1:0]             o_port0_width_field,
  output logic                   o_port0_w16,
  output logic [1:0]             o_port1_width_field,
  output logic                   o_port1_w16_mux,
  output logic [1:0]             o_port2_width_field,
  output logic [1:0]             o_port3_width_field,
  output logic [3:0]             o_boot_en,
  output logic [1:0]             o_boot_sel,
  output logic                   o_boot_valid
);

  pcfg_regs_t r;
  pcfg_regs_t next_r;

  // Ratio codes that name a legal ratio
  function automatic logic ratio_ok(input logic [2:0] code);
    case (code)
      3'h1, 3'h2, 3'h3, 3'h4, 3'h6: ratio_ok = 1'b1;
      default:                      ratio_ok = 1'b0;
    endcase
  endfunction : ratio_ok

  // Decode a captured strap word into settings
  function automatic pcfg_cfg_t decode(input logic [23:0] s);
    pcfg_cfg_t c;
    c = '0;
    c.powerup_status_bits = s[`PCFG_POWERUP_STATUS_BITS_HI:`PCFG_POWERUP_STATUS_BITS_LO];
    c.class_code_field    = s[`PCFG_CLASS_BIT];
    c.pci_arb_en          = s[`PCFG_PCI_ARB_BIT];
    c.cpu_arb_en          = s[`PCFG_CPU_ARB_BIT];
    // Only code 00 has a known base; others flag invalid
    c.base_valid = (s[`PCFG_BASE_HI:`PCFG_BASE_LO] == `PCFG_BASE_CODE0);
    c.base_addr  = c.base_valid ? `PCFG_BASE_ADDR0 : 32'h0;
    c.ratio       = pcfg_ratio_t'(s[`PCFG_RATIO_HI:`PCFG_RATIO_LO]);
    c.ratio_valid = ratio_ok(s[`PCFG_RATIO_HI:`PCFG_RATIO_LO]);
    c.port0_width_field = s[`PCFG_P0W_HI:`PCFG_P0W_LO];
    c.port0_w16 = (c.port0_width_field == `PCFG_P0_W16_CODE);
    c.port1_width_field = s[`PCFG_P1W_HI:`PCFG_P1W_LO];
    c.port1_w16_mux = (c.port1_width_field == `PCFG_P1_W16MUX_CODE);
    c.port2_width_field = s[`PCFG_P2W_HI:`PCFG_P2W_LO];
    c.port3_width_field = s[`PCFG_P3W_HI:`PCFG_P3W_LO];
    c.boot_en[0] = s[`PCFG_P0_BOOT_BIT];
    c.boot_en[1] = s[`PCFG_P1_BOOT_BIT] & ~s[`PCFG_P0_BOOT_BIT];
    c.boot_en[2] = s[`PCFG_P2_BOOT_BIT];
    c.boot_en[3] = s[`PCFG_P3_BOOT_BIT];
    // Port 0 wins the top range; port 1 only when port 0 is off
    if (c.boot_en[0]) begin
      c.boot_sel   = 2'h0;
      c.boot_valid = 1'b1;
    end else if (c.boot_en[1]) begin
      c.boot_sel   = 2'h1;
      c.boot_valid = 1'b1;
    end else begin
      c.boot_sel   = 2'h0;
      c.boot_valid = 1'b0;
    end
    return c;
  endfunction : decode

  // Next-state logic: synchronise, settle, capture once, serve reads
  always_comb begin
    next_r       = r;
    next_r.sync1 = i_config_strap_bus[23:0];
    next_r.sync2 = r.sync1;
    next_r.rdata = 32'h0;
    case (r.state)
      PCFG_ST_SYNC: begin
        // Wait for the synchroniser to fill with real pin levels
        next_r.cnt   = `PCFG_SETTLE_CYC;
        next_r.state = PCFG_ST_SETTLE;
      end
      PCFG_ST_SETTLE: begin
        if (r.cnt == 4'h0) begin
          next_r.raw    = r.sync2;
          next_r.cfg    = decode(r.sync2);
          next_r.locked = 1'b1;
          next_r.state  = PCFG_ST_LOCKED;
        end else begin
          next_r.cnt = r.cnt - 4'h1;
        end
      end
      PCFG_ST_LOCKED: begin
        // Pins are ignored from here until the next power-up reset
        next_r.state = PCFG_ST_LOCKED;
      end
      default: begin
        next_r.state = PCFG_ST_SYNC;
      end
    endcase
    // Register reads; writes have no target since every setting is strapped
    if (i_rd) begin
      case (i_addr)
        8'(`PCFG_REG_STATUS): next_r.rdata = {27'h0, r.locked, r.cfg.powerup_status_bits};
        8'(`PCFG_REG_CONFIG): next_r.rdata = {17'h0, r.cfg.port3_width_field,
                                              r.cfg.port2_width_field, r.cfg.port1_width_field,
                                              r.cfg.port0_width_field, r.cfg.ratio_valid,
                                              r.cfg.ratio, r.cfg.cpu_arb_en, r.cfg.pci_arb_en,
                                              r.cfg.class_code_field};
        8'(`PCFG_REG_BOOT):   next_r.rdata = {25'h0, r.cfg.boot_valid, r.cfg.boot_sel,
                                              r.cfg.boot_en};
        8'(`PCFG_REG_BASE):   next_r.rdata = r.cfg.base_addr;
        8'(`PCFG_REG_RAW):    next_r.rdata = {8'h0, r.raw};
        default:              next_r.rdata = 32'h0;
      endcase
    end
  end

  // State register; async reset loads constants only
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops
  assign o_rdata                      = r.rdata;
  assign o_cfg_valid                  = r.locked;
  assign o_powerup_status_bits        = r.cfg.powerup_status_bits;
  assign o_class_code_field           = r.cfg.class_code_field;
  assign o_pci_arb_en                 = r.cfg.pci_arb_en;
  assign o_cpu_arb_en                 = r.cfg.cpu_arb_en;
  assign o_bridge_register_group_base = r.cfg.base_addr;
  assign o_base_valid                 = r.cfg.base_valid;
  assign o_clk_ratio                  = r.cfg.ratio;
  assign o_clk_ratio_valid            = r.cfg.ratio_valid;
  assign o_port0_width_field          = r.cfg.port0_width_field;
  assign o_port0_w16                  = r.cfg.port0_w16;
  assign o_port1_width_field          = r.cfg.port1_width_field;
  assign o_port1_w16_mux              = r.cfg.port1_w16_mux;
  assign o_port2_width_field          = r.cfg.port2_width_field;
  assign o_port3_width_field          = r.cfg.port3_width_field;
  assign o_boot_en                    = r.cfg.boot_en;
  assign o_boot_sel                   = r.cfg.boot_sel;
  assign o_boot_valid                 = r.cfg.boot_valid;

endmodule : pcfg_strap_loader

/* File: pcfg_props.sv */
// Checker for the strap capture block ports
`timescale 1ns/1ps
module pcfg_props
  import pcfg_pkg::*;
#(
  parameter int STRAP_W = 24
) (
  // Clock and reset
  input wire logic               i_ref_clk,
  input wire logic               i_resetn,
  // Strap pins
  input wire logic [STRAP_W-1:0] i_config_strap_bus,
  // Decoded configuration
  input wire logic               o_cfg_valid,
  input wire logic [3:0]         o_powerup_status_bits,
  input wire logic               o_class_code_field,
  input wire logic               o_pci_arb_en,
  input wire logic               o_cpu_arb_en,
  input wire logic               o_base_valid,
  input wire logic [31:0]        o_bridge_register_group_base,
  input wire pcfg_ratio_t        o_clk_ratio,
  input wire logic               o_clk_ratio_valid,
  input wire logic               o_port0_w16,
  input wire logic               o_port1_w16_mux,
  input wire logic [3:0]         o_boot_en,
  input wire logic [1:0]         o_boot_sel,
  input wire logic               o_boot_valid
);
  // One domain, so one clocking and one disable
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // Capture lands on the fifth edge after release
  property p_lock;
    $rose(i_resetn) |-> !o_cfg_valid [*5] ##1 o_cfg_valid;
  endproperty
  a_lock: assert property (p_lock) else $error("capture not on fifth edge");
  // Straps are stable around capture, so the value two edges back is the captured one
  property p_status;
    $rose(o_cfg_valid) |-> o_powerup_status_bits == $past(i_config_strap_bus[23:20], 2);
  endproperty
  a_status: assert property (p_status) else $error("status bits wrong");
  property p_class;
    $rose(o_cfg_valid) |-> o_class_code_field == $past(i_config_strap_bus[19], 2);
  endproperty
  a_class: assert property (p_class) else $error("class code wrong");
  property p_arb;
    $rose(o_cfg_valid) |-> {o_pci_arb_en, o_cpu_arb_en} == $past(i_config_strap_bus[18:17], 2);
  endproperty
  a_arb: assert property (p_arb) else $error("arbiter enables wrong");
  property p_base;
    $rose(o_cfg_valid) |-> o_base_valid == ($past(i_config_strap_bus[16:15], 2) == 2'h0);
  endproperty
  a_base: assert property (p_base) else $error("base flag wrong");
  // Base address itself, zero for codes without a known base
  property p_base_addr;
    $rose(o_cfg_valid) |-> o_bridge_register_group_base ==
      (($past(i_config_strap_bus[16:15], 2) == 2'h0) ? 32'hfeff0000 : 32'h0);
  endproperty
  a_base_addr: assert property (p_base_addr) else $error("base address wrong");
  property p_ratio;
    $rose(o_cfg_valid) |-> o_clk_ratio_valid == ($past(i_config_strap_bus[14:12], 2) inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6});
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio flag wrong");
  property p_width;
    $rose(o_cfg_valid) |-> o_port0_w16 == ($past(i_config_strap_bus[11:10], 2) == 2'h1)
      && o_port1_w16_mux == ($past(i_config_strap_bus[8:7], 2) == 2'h3);
  endproperty
  a_width: assert property (p_width) else $error("port width flags wrong");
  property p_boot_sel;
    o_cfg_valid |-> o_boot_valid == (o_boot_en[0] | o_boot_en[1]) && (!o_boot_valid || o_boot_sel == {1'b0, ~o_boot_en[0]});
  endproperty
  a_boot_sel: assert property (p_boot_sel) else $error("boot selection wrong");
  // Pins may wander after capture; the settings must not
  property p_hold;
    o_cfg_valid && $past(o_cfg_valid) |-> $stable(o_powerup_status_bits) && $stable(o_boot_en) && $stable(o_clk_ratio);
  endproperty
  a_hold: assert property (p_hold) else $error("settings moved after capture");
endmodule : pcfg_props

/* File: pcfg_strap_board.sv */
// Board strap resistors and jumpers feeding the strap pins
`timescale 1ns/1ps
module pcfg_strap_board (
  // Pattern fitted on the board
  input  wire logic [23:0] i_fitted,
  // Pin levels
  output logic      [23:0] o_pins
);
  // Static resistors: every pin always driven, one level per bit
  assign o_pins = i_fitted;
endmodule : pcfg_strap_board

/* File: test_powerup_strap_config.sv */
// Testbench for the strap capture block
`timescale 1ns/1ps
module test_powerup_strap_config;
  import pcfg_pkg::*;
  localparam logic [7:0] ADDRS [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
  logic        i_ref_clk = 1'b0;
  logic        i_resetn  = 1'b0;
  logic [23:0] fitted    = 24'h0;
  logic [23:0] pins;
  logic [7:0]  i_addr    = 8'h0;
  logic [31:0] i_wdata   = 32'h0;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic [31:0] o_rdata;
  logic        o_cfg_valid;
  logic        rd_d      = 1'b0;
  logic [23:0] s;
  logic [31:0] exp_q [$];
  int          miscompares = 0;
  int          checked     = 0;

  // Clock
  always #12.5 i_ref_clk = ~i_ref_clk;

  pcfg_strap_board i_pcfg_strap_board (.i_fitted(fitted), .o_pins(pins));
  pcfg_strap_loader i_pcfg_strap_loader (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_config_strap_bus(pins), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cfg_valid(o_cfg_valid),
    .o_powerup_status_bits(), .o_class_code_field(), .o_pci_arb_en(), .o_cpu_arb_en(),
    .o_bridge_register_group_base(), .o_base_valid(), .o_clk_ratio(), .o_clk_ratio_valid(),
    .o_port0_width_field(), .o_port0_w16(), .o_port1_width_field(), .o_port1_w16_mux(),
    .o_port2_width_field(), .o_port3_width_field(), .o_boot_en(), .o_boot_sel(), .o_boot_valid());

  // Expected read word for a captured strap value
  function automatic logic [31:0] expect_rd(input logic [7:0] a, input logic [23:0] v);
    logic rv;
    rv = v[14:12] inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
    case (a)
      8'h00: return {27'h0, 1'b1, v[23:20]};
      8'h04: return {17'h0, v[2:1], v[5:4], v[8:7], v[11:10], rv, v[14:12], v[17], v[18], v[19]};
      8'h08: return {25'h0, v[9] | v[6], 1'b0, ~v[9] & v[6], v[0], v[3], v[6] & ~v[9], v[9]};
      8'h0c: return (v[16:15] == 2'h0) ? 32'hfeff0000 : 32'h0;
      8'h10: return {8'h0, v};
      default: return 32'h0;
    endcase
  endfunction : expect_rd

  // Read strobe, left high so successive calls run back to back
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    i_rd   <= 1'b1;
    i_wr   <= 1'b0;
    i_addr <= a;
    exp_q.push_back(e);
  endtask : rd

  task automatic compare_rd(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR o_rdata expected %h seen %h", e, g);
    end
  endtask : compare_rd

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Read data stands only in the cycle after the strobe
  always @(posedge i_ref_clk) begin
    if (rd_d && exp_q.size() > 0) begin
      compare_rd(exp_q.pop_front(), o_rdata);
    end
    rd_d <= i_rd;
  end

  // Each pass: new straps under reset, check, disturb pins, check again
  initial begin
    void'($urandom(32'hfa83));
    for (int n = 0; n < 12; n++) begin
      @(posedge i_ref_clk);
      s = 24'($urandom);
      s[14:12] = 3'(n);
      s[16:15] = 2'(n);
      s[9] = n[2];
      s[6] = n[1];
      i_resetn <= 1'b0;
      fitted   <= s;
      repeat (4) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      for (int k = 0; k < 20 && o_cfg_valid !== 1'b1; k++) @(posedge i_ref_clk);
      if (o_cfg_valid !== 1'b1) begin
        miscompares++;
        break;
      end
      foreach (ADDRS[k]) rd(ADDRS[k], expect_rd(ADDRS[k], s));
      @(posedge i_ref_clk);
      i_rd    <= 1'b0;
      i_wr    <= 1'b1;
      i_wdata <= $urandom;
      fitted  <= ~s;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
      repeat (4) @(posedge i_ref_clk);
      // Pins now inverted; captured values must not follow them
      foreach (ADDRS[k]) rd(ADDRS[k], expect_rd(ADDRS[k], s));
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
      $display("test %0d done", n);
    end
    give_verdict();
  end
endmodule : test_powerup_strap_config

bind pcfg_strap_loader pcfg_props #(.STRAP_W(STRAP_W)) i_pcfg_props (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_config_strap_bus(i_config_strap_bus),
  .o_cfg_valid(o_cfg_valid), .o_powerup_status_bits(o_powerup_status_bits),
  .o_class_code_field(o_class_code_field), .o_pci_arb_en(o_pci_arb_en), .o_cpu_arb_en(o_cpu_arb_en),
  .o_base_valid(o_base_valid), .o_bridge_register_group_base(o_bridge_register_group_base),
  .o_clk_ratio(o_clk_ratio), .o_clk_ratio_valid(o_clk_ratio_valid), .o_port0_w16(o_port0_w16),
  .o_port1_w16_mux(o_port1_w16_mux), .o_boot_en(o_boot_en), .o_boot_sel(o_boot_sel),
  .o_boot_valid(o_boot_valid));
